// File: inc/bpl_pkg.sv
package bpl_pkg;
   // Clock and bit-time limits
   localparam int  CLK_MHZ        = 100;
   localparam real BIT_MIN_MS     = 0.01;
   localparam real BIT_MAX_MS     = 1.1;
   localparam int  BIT_MIN_CYC    = int'(BIT_MIN_MS * 1000.0 * CLK_MHZ);
   localparam int  BIT_MAX_CYC    = int'(BIT_MAX_MS * 1000.0 * CLK_MHZ);
   localparam int  CNT_W          = 18;
   // Sync pulse must be at least this many bit times long
   localparam int  SYNC_MULT      = 2;
   localparam int  WORD_W         = 24;
   localparam int  ADDR_W         = 4;
   localparam int  DATA_W         = 16;
   localparam int  LOCK_BIT       = 15;
   localparam int  SUPV_ADDR      = 4'h1;
   localparam int  TEMP_ADDR      = 4'h2;
   // Command codes in bits 23:20
   localparam logic [3:0] CMD_READ  = 4'h1;
   localparam logic [3:0] CMD_WRITE = 4'h2;
   // Temperature scaling, gains and SENT offset fixed point with 2 fraction bits
   localparam logic [15:0] TADJ_GAIN_Q2 = 16'h0165;
   localparam logic [15:0] TADJ_OFS     = 16'h0e88;
   localparam logic [15:0] TSENT_GAIN_Q2 = 16'h0020;
   localparam logic [15:0] TSENT_OFS_Q2  = 16'h0926;
   localparam logic [15:0] SUPV_RESET   = 16'h0000;

   typedef struct packed {
      logic [3:0]        cmd;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
   } bpl_word_t;

   typedef enum logic [2:0] {
      ST_APP  = 3'b000,
      ST_SYNC = 3'b001,
      ST_LIST = 3'b011,
      ST_TX   = 3'b010
   } bpl_state_t;
endpackage

// File: verilog/bpl_buf2.sv
`timescale 1ns/1ns
module bpl_buf2 #(
   parameter int WIDTH = 24
) (
   // Clock and reset
   input  wire logic             mclk,
   input  wire logic             reset_n,
   // Fill side
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   // Drain side
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic [WIDTH-1:0]      out_data
);
   logic [WIDTH-1:0] mem [2];
   logic             wr_idx;
   logic             rd_idx;
   logic [1:0]       count;

   assign in_ready  = (count != 2'h2);
   assign out_valid = (count != 2'h0);
   assign out_data  = mem[rd_idx];

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         wr_idx <= 1'b0;
         rd_idx <= 1'b0;
         count  <= 2'h0;
      end else begin
         if (in_valid && in_ready)
            wr_idx <= ~wr_idx;
         if (out_valid && out_ready)
            rd_idx <= ~rd_idx;
         count <= count + 2'(in_valid && in_ready)
                        - 2'(out_valid && out_ready);
      end
   end

   always_ff @(posedge mclk) begin
      if (in_valid && in_ready)
         mem[wr_idx] <= in_data;
   end
endmodule

// File: verilog/bpl_link.sv
`timescale 1ns/1ns
// How it works
// - After reset the block sits in application mode and does not drive the pin.
// - The rising end of a long enough low sync pulse moves it to listening mode.
// - A bit period with no inner transition decodes as 0.
// - A bit period with a transition near its middle decodes as 1.
// - Every bit period ends in a transition, which resynchronises timing.
// - Answers go back on the same pin with the same biphase coding.
// - Telegrams carry commands and register words; answers return the supervision word or temperature adjust value.
// - A written lock bit takes effect only after the next reset.
// - Once locked, write commands leave the stored contents unchanged.
// - A locked device still answers reads with good CRC and overcurrent on.
// - Temperature for the SENT channels is 8.0 LSB/degC plus 585.5 LSB.
// - The temperature adjust value is 89.25 LSB/degC plus 3720 LSB.
module bpl_link (
   // Clock and reset
   input  wire logic        mclk,
   input  wire logic        reset_n,
   // Output pin, two-way
   input  wire logic        pin_in,
   output logic             pin_out,
   output logic             pin_oe,
   // Status and sensor side
   input  wire logic        crc_ok,
   input  wire logic        ocd_disabled,
   input  wire logic signed [9:0] temp_degc,
   output logic             prog_mode,
   output logic             lock_active,
   output logic [15:0]      temperature_adjust_value,
   output logic [11:0]      temp_sent,
   output logic [15:0]      supervision_setup_reg
);
   logic              pin_s1, pin_s2, pin_d;
   bpl_pkg::bpl_state_t state;
   logic [bpl_pkg::CNT_W-1:0] cnt, bit_cyc;
   logic              mid_seen;
   logic [4:0]        nbits;
   logic [bpl_pkg::WORD_W-1:0] shreg;
   logic              rx_valid, rx_ready;
   logic [bpl_pkg::WORD_W-1:0] rx_data;
   bpl_pkg::bpl_word_t cmd_w;
   logic              tx_pend;
   logic [bpl_pkg::WORD_W-1:0] tx_sh;
   logic [4:0]        tx_n;
   logic              edge_in;
   logic [31:0]       tadj_raw, tsent_raw;
   logic              rx_valid_q, rx_in_ready, supv_write;
   logic              lock_taken;
   // Stored word survives reset, as the nonvolatile copy does
   logic [15:0]       nv_supv = bpl_pkg::SUPV_RESET;

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         // Idle line is high; a low reset value would fake an edge
         pin_s1 <= 1'b1;
         pin_s2 <= 1'b1;
         pin_d  <= 1'b1;
      end else begin
         pin_s1 <= pin_in;
         pin_s2 <= pin_s1;
         pin_d  <= pin_s2;
      end
   end
   assign edge_in = pin_s2 ^ pin_d;

   // Receiver and mode machine
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         state    <= bpl_pkg::ST_APP;
         cnt      <= '0;
         bit_cyc  <= '0;
         mid_seen <= 1'b0;
         nbits    <= '0;
         shreg    <= '0;
         rx_valid <= 1'b0;
      end else begin
         if (rx_valid && rx_in_ready)
            rx_valid <= 1'b0;
         if (cnt != '1)
            cnt <= cnt + 1'b1;
         unique case (state)
            bpl_pkg::ST_APP: begin
               if (edge_in) begin
                  cnt   <= '0;
                  state <= bpl_pkg::ST_SYNC;
               end
            end
            bpl_pkg::ST_SYNC: begin
               // sync measures period
               // Sync is a low pulse, so only its rising end counts
               if (edge_in) begin
                  if (pin_s2 && cnt >= bpl_pkg::CNT_W'(bpl_pkg::SYNC_MULT
                                 * bpl_pkg::BIT_MIN_CYC - 1)) begin
                     bit_cyc  <= (cnt + 1'b1) >> 1;
                     state    <= bpl_pkg::ST_LIST;
                     nbits    <= '0;
                     mid_seen <= 1'b0;
                  end
                  cnt <= '0;
               end
            end
            bpl_pkg::ST_LIST: begin
               if (edge_in) begin
                  if (cnt < (bit_cyc >> 2) + (bit_cyc >> 1)) begin
                     mid_seen <= 1'b1;
                  end else begin
                     shreg    <= {shreg[bpl_pkg::WORD_W-2:0], mid_seen};
                     mid_seen <= 1'b0;
                     cnt      <= '0;
                     if (nbits == 5'(bpl_pkg::WORD_W - 1)) begin
                        nbits    <= '0;
                        rx_valid <= 1'b1;
                     end else
                        nbits <= nbits + 1'b1;
                  end
               end else if (cnt > bit_cyc + bit_cyc) begin
                  // Quiet line ends the telegram; wait for a new sync
                  nbits    <= '0;
                  mid_seen <= 1'b0;
                  state    <= bpl_pkg::ST_SYNC;
               end
               // Turnaround: one quiet bit lets the host release the pin
               if (tx_pend && cnt >= bit_cyc) begin
                  cnt   <= '0;
                  state <= bpl_pkg::ST_TX;
               end
            end
            bpl_pkg::ST_TX: begin
               if (!tx_pend) begin
                  cnt   <= '0;
                  state <= bpl_pkg::ST_LIST;
               end else if (cnt == bit_cyc - 1'b1)
                  cnt <= '0;
            end
            default: state <= bpl_pkg::ST_APP;
         endcase
      end
   end

   bpl_buf2 #(
      .WIDTH (bpl_pkg::WORD_W)
   ) u_buf (
      .mclk      (mclk),
      .reset_n   (reset_n),
      .in_valid  (rx_valid),
      .in_ready  (rx_in_ready),
      .in_data   (shreg),
      .out_valid (rx_valid_q),
      .out_ready (rx_ready),
      .out_data  (rx_data)
   );
   assign cmd_w    = bpl_pkg::bpl_word_t'(rx_data);
   assign rx_ready = !tx_pend;
   assign supv_write = rx_valid_q && rx_ready && !lock_active
                       && cmd_w.cmd == bpl_pkg::CMD_WRITE
                       && cmd_w.addr == 4'(bpl_pkg::SUPV_ADDR);

   // Nonvolatile copy, kept across reset on purpose
   always_ff @(posedge mclk) begin
      if (supv_write)
         nv_supv <= cmd_w.data;
   end

   // Command execution
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         supervision_setup_reg <= bpl_pkg::SUPV_RESET;
         lock_active           <= 1'b0;
         tx_pend               <= 1'b0;
         tx_sh                 <= '0;
         tx_n                  <= '0;
         pin_out               <= 1'b0;
         pin_oe                <= 1'b0;
         prog_mode             <= 1'b0;
      end else begin
         prog_mode <= (state != bpl_pkg::ST_APP);
         // lock taken from the stored word just after reset
         if (!lock_taken) begin
            supervision_setup_reg <= nv_supv;
            lock_active           <= nv_supv[bpl_pkg::LOCK_BIT];
         end
         if (rx_valid_q && rx_ready) begin
            if (supv_write)
               supervision_setup_reg <= cmd_w.data;
            // locked reads need crc and ocd
            if (cmd_w.cmd == bpl_pkg::CMD_READ
                && (!lock_active || (crc_ok && !ocd_disabled))) begin
               tx_pend <= 1'b1;
               tx_n    <= '0;
               tx_sh   <= {cmd_w.cmd, cmd_w.addr,
                  (cmd_w.addr == 4'(bpl_pkg::TEMP_ADDR)) ?
                  temperature_adjust_value : supervision_setup_reg};
            end
         end
         if (tx_pend && state == bpl_pkg::ST_TX) begin
            pin_oe <= 1'b1;
            if (cnt == bit_cyc - 1'b1) begin
               pin_out <= ~pin_out;
               tx_sh   <= tx_sh << 1;
               tx_n    <= tx_n + 1'b1;
               if (tx_n == 5'(bpl_pkg::WORD_W - 1)) begin
                  tx_pend <= 1'b0;
                  pin_oe  <= 1'b0;
               end
            end else if (cnt == (bit_cyc >> 1) - 1'b1
                         && tx_sh[bpl_pkg::WORD_W-1])
               pin_out <= ~pin_out;
         end
      end
   end

   assign tadj_raw  = 32'($signed(temp_degc)
                      * $signed({1'b0, bpl_pkg::TADJ_GAIN_Q2}));
   assign tsent_raw = 32'($signed(temp_degc)
                      * $signed({1'b0, bpl_pkg::TSENT_GAIN_Q2})
                      + $signed({16'h0, bpl_pkg::TSENT_OFS_Q2}));
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         temperature_adjust_value <= bpl_pkg::TADJ_OFS;
         temp_sent                <= '0;
      end else begin
         temperature_adjust_value <= 16'(tadj_raw >>> 2) + bpl_pkg::TADJ_OFS;
         temp_sent                <= 12'(tsent_raw >>> 2);
      end
   end

   // Lock bit sampled while reset releases
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n)
         lock_taken <= 1'b0;
      else if (!lock_taken)
         lock_taken <= 1'b1;
   end

   bpl_lock_a: assert property (@(posedge mclk) disable iff (!reset_n)
      lock_active |=> $stable(supervision_setup_reg))
      else $error("locked register changed");
   app_idle_a: assert property (@(posedge mclk) disable iff (!reset_n)
      state == bpl_pkg::ST_APP |-> !pin_oe)
      else $error("driving in application mode");
   lock_hold_a: assert property (@(posedge mclk) disable iff (!reset_n)
      $past(lock_taken) |-> $stable(lock_active))
      else $error("lock changed without reset");
   oe_answer_a: assert property (@(posedge mclk) disable iff (!reset_n)
      pin_oe |-> tx_pend)
      else $error("pin driven outside an answer");
   read_refuse_a: assert property (@(posedge mclk) disable iff (!reset_n)
      rx_valid_q && rx_ready && cmd_w.cmd == bpl_pkg::CMD_READ
      && lock_active && (!crc_ok || ocd_disabled) |=> !tx_pend)
      else $error("locked read answered without checks");
   prog_mode_a: assert property (@(posedge mclk) disable iff (!reset_n)
      prog_mode |-> $past(state) != bpl_pkg::ST_APP)
      else $error("prog mode without sync");
   tx_cover_c: cover property (@(posedge mclk) tx_pend ##1 !tx_pend);
   list_cover_c: cover property (@(posedge mclk)
      state == bpl_pkg::ST_LIST);
   word_cover_c: cover property (@(posedge mclk) rx_valid);
endmodule

// File: test/bpl_host_model.sv
`timescale 1ns/1ns
module bpl_host_model #(
   parameter int BIT_CYC = bpl_pkg::BIT_MIN_CYC
) (
   // Clock
   input  wire logic mclk,
   // Pin as the host sees it
   input  wire logic pin_level,
   input  wire logic dev_oe,
   output logic      host_oe,
   output logic      host_drv
);
   initial begin
      host_oe  = 1'b0;
      host_drv = 1'b1;
   end

   task automatic hold(input int n);
      repeat (n) @(negedge mclk);
   endtask

   task automatic send_word(input bpl_pkg::bpl_word_t w);
      logic [23:0] b;
      b = w;
      @(negedge mclk);
      host_oe  = 1'b1;
      host_drv = 1'b0;
      hold(bpl_pkg::SYNC_MULT * BIT_CYC);
      host_drv = 1'b1;
      for (int i = 23; i >= 0; i--) begin
         // shortest legal bit, mid toggle for one
         hold(BIT_CYC / 2);
         if (b[i])
            host_drv = ~host_drv;
         hold(BIT_CYC / 2);
         host_drv = ~host_drv;
      end
      // Let go early so the answer never fights a held pin
      hold(BIT_CYC / 4);
      host_oe = 1'b0;
   endtask

   // answer decoded by level at one and three quarters
   task automatic read_answer(output logic [23:0] a, output logic seen);
      logic s0;
      int   n;
      a    = '0;
      n    = 0;
      while (dev_oe !== 1'b1 && n < 4 * BIT_CYC) begin
         @(negedge mclk);
         n++;
      end
      seen = (dev_oe === 1'b1);
      for (int i = 23; i >= 0; i--) begin
         hold(BIT_CYC / 4);
         s0 = pin_level;
         hold(BIT_CYC / 2);
         a[i] = (pin_level !== s0);
         hold(BIT_CYC / 4);
      end
   endtask
endmodule

// File: test/bpl_link_tb_top.sv
`timescale 1ns/1ns
module bpl_link_tb_top;
   logic              mclk;
   logic              reset_n;
   logic              pin_line;
   logic              pin_out;
   logic              pin_oe;
   logic              host_oe;
   logic              host_drv;
   logic              crc_ok;
   logic              ocd_disabled;
   logic signed [9:0] temp_degc;
   logic              prog_mode;
   logic              lock_active;
   logic [15:0]       temperature_adjust_value;
   logic [11:0]       temp_sent;
   logic [15:0]       supervision_setup_reg;
   int                n_mismatch = 0;
   int                comparisons = 0;
   int                cycles = 0;

   // Pull-up wins when nobody drives
   assign pin_line = pin_oe ? pin_out : (host_oe ? host_drv : 1'b1);

   bpl_link uut (.mclk(mclk), .reset_n(reset_n), .pin_in(pin_line),
      .pin_out(pin_out), .pin_oe(pin_oe), .crc_ok(crc_ok),
      .ocd_disabled(ocd_disabled), .temp_degc(temp_degc),
      .prog_mode(prog_mode), .lock_active(lock_active),
      .temperature_adjust_value(temperature_adjust_value),
      .temp_sent(temp_sent), .supervision_setup_reg(supervision_setup_reg));

   bpl_host_model hm (.mclk(mclk), .pin_level(pin_line), .dev_oe(pin_oe),
      .host_oe(host_oe), .host_drv(host_drv));

   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end

   task automatic test_done();
      if (n_mismatch == 0 && comparisons > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   always @(posedge mclk) begin
      cycles <= cycles + 1;
      if (cycles == 108000) begin
         n_mismatch++;
         test_done();
      end
   end

   task automatic check(input logic [23:0] seen, input logic [23:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic do_reset();
      @(negedge mclk);
      reset_n = 1'b0;
      repeat (16) @(negedge mclk);
      reset_n = 1'b1;
      repeat (4) @(negedge mclk);
   endtask

   task automatic t_reset_state();
      check(24'(prog_mode), 24'h000000);
      check(24'(pin_oe), 24'h000000);
      check(24'(lock_active), 24'h000000);
   endtask

   task automatic t_temp();
      logic [11:0] s0;
      logic [11:0] d;
      temp_degc = 10'h004;
      repeat (8) @(negedge mclk);
      check(24'(temperature_adjust_value), 24'h000fed);
      temp_degc = 10'h3f8;
      repeat (8) @(negedge mclk);
      check(24'(temperature_adjust_value), 24'h000bbe);
      temp_degc = 10'h000;
      repeat (8) @(negedge mclk);
      s0 = temp_sent;
      check(24'(s0 === 12'h249 || s0 === 12'h24a), 24'h000001);
      temp_degc = 10'h014;
      repeat (8) @(negedge mclk);
      d = temp_sent - s0;
      check(24'(d), 24'h0000a0);
   endtask

   task automatic t_lock_write();
      int n;
      n = 0;
      // Locking word carries the lock bit
      hm.send_word({bpl_pkg::CMD_WRITE, 4'(bpl_pkg::SUPV_ADDR), 16'h8000});
      check(24'(prog_mode), 24'h000001);
      while (supervision_setup_reg !== 16'h8000 && n < 200) begin
         @(negedge mclk);
         n++;
      end
      check(24'(supervision_setup_reg), 24'h008000);
      check(24'(lock_active), 24'h000000);
      do_reset();
      check(24'(lock_active), 24'h000001);
      check(24'(prog_mode), 24'h000000);
   endtask

   task automatic t_locked();
      logic [23:0] a;
      logic        seen;
      hm.send_word({bpl_pkg::CMD_WRITE, 4'(bpl_pkg::SUPV_ADDR), 16'h0000});
      // Over two quiet bits, so the receiver waits for a fresh sync
      repeat (1800) @(negedge mclk);
      check(24'(supervision_setup_reg), 24'h008000);
      crc_ok       = 1'b1;
      ocd_disabled = 1'b0;
      hm.send_word({bpl_pkg::CMD_READ, 4'(bpl_pkg::SUPV_ADDR), 16'h0000});
      hm.read_answer(a, seen);
      check(24'(seen), 24'h000001);
      check(24'(a[15:0]), 24'h008000);
   endtask

   initial begin
      reset_n      = 1'b0;
      crc_ok       = 1'b1;
      ocd_disabled = 1'b0;
      temp_degc    = 10'h000;
      do_reset();
      t_reset_state();
      t_temp();
      t_lock_write();
      t_locked();
      test_done();
   end
endmodule
